//--- core/aoa_count.sv
// Per-decoder sample counter with first-pulse flag
`timescale 1ns/10ps
module aoa_count
	import aoa_word_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clear,
	input wire logic sample,
	output logic seen,
	output logic [COUNT_W-1:0] count
);
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			seen <= 1'b0;
			count <= '0;
		end
		else if (sample)
		begin
			// A sample in the clear cycle starts a fresh reply, it is not lost
			seen <= 1'b1;
			count <= (clear || !seen) ? COUNT_ONE : ((count == COUNT_MAX) ? count : count + COUNT_ONE);
		end
		else if (clear)
		begin
			seen <= 1'b0;
			count <= '0;
		end
	end
endmodule

//--- core/aoa_fifo.sv
// Parameterised valid/ready FIFO of flip-flops
`timescale 1ns/10ps
module aoa_fifo
#(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0] wr_reg;
	logic [AW-1:0] rd_reg;
	logic [AW:0] cnt_reg;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;
	assign in_ready = (cnt_reg != DEPTH[AW:0]);
	assign out_valid = (cnt_reg != '0);
	assign out_data = mem_reg[rd_reg];
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_reg <= '0;
			rd_reg <= '0;
			cnt_reg <= '0;
		end
		else
		begin
			if (push)
				wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
			if (pop)
				rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
			cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
	always_ff @(posedge clk)
	begin
		if (push)
			mem_reg[wr_reg] <= in_data;
	end
endmodule

//--- core/aoa_word_framer.sv
// Angle-of-arrival result word framer: first and second output buffers, word out
// Functional notes
// R01 - Valid flag in MSB, set only if valid
// R02 - Averaged bearing in byte, 1/256 circle
// R03 - Mode S count is always 32
// R04 - ATCRBS count: data ones plus first pulse
// R05 - Garble or abandoned sampling lowers count
// R06 - Same word layout in both modes
// R07 - Host negates bottom-antenna bearings
// R08 - Count between flag and bearing, zero-filled
// R09 - Mode S word sent tenth on request
// R10 - ATCRBS word fourth, on read strobe
// R11 - Valid from decoder first-seen status
// R12 - Mode S always uses slot 01; the reply start still clears START_DECODER, not slot 01
`timescale 1ns/10ps
module aoa_word_framer
	import aoa_word_pkg::*;
(
	input wire logic MCLK,
	input wire logic RESETN,
	input wire logic MODE_SEL,
	input wire logic REPLY_START,
	input wire logic [DEC_W-1:0] START_DECODER,
	input wire logic SAMPLE_STROBE,
	input wire logic [DEC_W-1:0] DECODER_SLOT_ADDRESS,
	input wire logic [BEARING_W-1:0] AVG_BEARING,
	input wire logic REPLY_DONE,
	input wire logic [DEC_W-1:0] DONE_DECODER,
	input wire logic [SLOT_W-1:0] WRITE_SLOT,
	input wire logic [SLOT_W-1:0] READ_SLOT,
	input wire logic WORD_REQUEST,
	output logic COMMIT_READY,
	output logic WORD_VALID,
	input wire logic WORD_READY,
	output logic [WORD_W-1:0] RESULT_WORD
);
	// ==========================================
	// Decoding
	reply_mode_e mode;
	assign mode = MODE_SEL ? MODE_MODES : MODE_ATCRBS;
	// Mode S replies always land in slot 01
	wire logic [DEC_W-1:0] sample_dec = (mode == MODE_MODES) ? MODES_SLOT : DECODER_SLOT_ADDRESS; // R12
	wire logic [DEC_W-1:0] done_dec = (mode == MODE_MODES) ? MODES_SLOT : DONE_DECODER; // R12
	wire logic [SLOT_W-1:0] wslot = (mode == MODE_MODES) ? MODES_SLOT : WRITE_SLOT; // R12
	wire logic [SLOT_W-1:0] rslot = (mode == MODE_MODES) ? MODES_SLOT : READ_SLOT; // R12
	// ==========================================
	// First output buffer: live bearing, count and first-seen flag per decoder
	logic [DEC_N-1:0] decoder_first_seen_flag;
	logic [COUNT_W-1:0] dec_count [DEC_N];
	logic [BEARING_W-1:0] bearing_reg [DEC_N];
	genvar g;
	generate
		for (g = 0; g < DEC_N; g++)
		begin : g_dec
			wire logic clr = REPLY_START && (START_DECODER == DEC_W'(g));
			wire logic smp = SAMPLE_STROBE && (sample_dec == DEC_W'(g));
			// Every ungarbled sample counts once, up to 127; missed samples simply never arrive
			aoa_count u_cnt
			(
				.clk(MCLK),
				.rst_n(RESETN),
				.clear(clr),
				.sample(smp),
				.seen(decoder_first_seen_flag[g]),
				.count(dec_count[g])
			); // R04 R05
			always_ff @(posedge MCLK or negedge RESETN)
			begin
				if (!RESETN)
					bearing_reg[g] <= '0;
				else if (smp)
					bearing_reg[g] <= AVG_BEARING;
			end
		end
	endgenerate
	// ==========================================
	// Word assembly, one layout for both modes
	wire logic angle_valid_flag = decoder_first_seen_flag[done_dec]; // R11
	wire logic [COUNT_W-1:0] word_count = (mode == MODE_MODES) ? MODES_COUNT : dec_count[done_dec]; // R03 R04
	logic [WORD_W-1:0] assembled;
	always_comb
	begin
		assembled = '0; // R08
		assembled[VALID_BIT] = angle_valid_flag; // R01 R06
		assembled[COUNT_HI:COUNT_LO] = word_count; // R08 R06
		// Raw bearing; bottom antenna negation is left to the consumer
		assembled[BEARING_HI:BEARING_LO] = bearing_reg[done_dec]; // R02 R06 R07
	end
	// ==========================================
	// Second output buffer, addressed like the reply processor buffer
	logic [WORD_W-1:0] slot_reg [SLOT_N];
	logic commit_pend_reg;
	logic [WORD_W-1:0] commit_word_reg;
	logic [SLOT_W-1:0] commit_slot_reg;
	// A finished reply is held here one cycle; one that finishes while the previous is still held is refused
	assign COMMIT_READY = !commit_pend_reg;
	always_ff @(posedge MCLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			commit_pend_reg <= 1'b0;
			commit_word_reg <= '0;
			commit_slot_reg <= '0;
		end
		else if (REPLY_DONE && !commit_pend_reg)
		begin
			commit_pend_reg <= 1'b1;
			commit_word_reg <= assembled; // R11
			commit_slot_reg <= wslot;
		end
		else
			commit_pend_reg <= 1'b0;
	end
	always_ff @(posedge MCLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			for (int i = 0; i < SLOT_N; i++)
				slot_reg[i] <= '0;
		end
		else if (commit_pend_reg)
			slot_reg[commit_slot_reg] <= commit_word_reg;
	end
	// ==========================================
	// Readout: request pushes the addressed word into the outgoing FIFO
	logic fifo_in_ready;
	wire logic push = WORD_REQUEST && fifo_in_ready; // R09 R10
	// Requests while the FIFO is full are dropped; the reply processor paces them
	aoa_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo
	(
		.clk(MCLK),
		.rst_n(RESETN),
		.in_valid(push),
		.in_ready(fifo_in_ready),
		.in_data(slot_reg[rslot]),
		.out_valid(WORD_VALID),
		.out_ready(WORD_READY),
		.out_data(RESULT_WORD)
	); // R09 R10
endmodule

//--- shared/aoa_word_pkg.sv
// Shared constants for the angle-of-arrival result word framer
package aoa_word_pkg;
	// ==========================================
	// Word layout, bit 15 is the MSB of the printed word
	localparam int WORD_W = 16;
	localparam int VALID_BIT = 15;
	localparam int COUNT_HI = 14;
	localparam int COUNT_LO = 8;
	localparam int COUNT_W = 7;
	localparam int BEARING_W = 8;
	localparam int BEARING_HI = 7;
	localparam int BEARING_LO = 0;
	// ==========================================
	// Counts and buffer geometry
	localparam logic [COUNT_W-1:0] MODES_COUNT = 7'h20;
	localparam logic [COUNT_W-1:0] COUNT_ONE = 7'h01;
	localparam logic [COUNT_W-1:0] COUNT_MAX = 7'h7f;
	localparam int DEC_N = 4;
	localparam int DEC_W = 2;
	localparam logic [DEC_W-1:0] MODES_SLOT = 2'h1;
	localparam int SLOT_N = 4;
	localparam int SLOT_W = 2;
	localparam int FIFO_DEPTH = 8;
	localparam int DATA_BITS = 12;
	// ==========================================
	// Reply modes
	typedef enum logic {MODE_ATCRBS, MODE_MODES} reply_mode_e;
endpackage

//--- sim/aoa_chk_asserts.sv
// Port assertions for the result word framer
`timescale 1ns/10ps
module aoa_chk
	import aoa_word_pkg::*;
(
	input wire logic MCLK,
	input wire logic RESETN,
	input wire logic MODE_SEL,
	input wire logic REPLY_DONE,
	input wire logic COMMIT_READY,
	input wire logic WORD_REQUEST,
	input wire logic WORD_VALID,
	input wire logic WORD_READY,
	input wire logic [WORD_W-1:0] RESULT_WORD
);
	// ======
	// Handshakes
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RESETN);
	AST_TAKE: assert property (REPLY_DONE && COMMIT_READY |=> !COMMIT_READY) else $error("take");
	AST_REOPEN: assert property (!COMMIT_READY |=> COMMIT_READY) else $error("reopen");
	AST_ANSWER: assert property (WORD_REQUEST && !WORD_VALID |=> WORD_VALID) else $error("answer");
	AST_HOLD: assert property (WORD_VALID && !WORD_READY |=> WORD_VALID && $stable(RESULT_WORD)) else $error("hold");
	AST_QUIET: assert property (!WORD_VALID && !WORD_REQUEST |=> !WORD_VALID) else $error("quiet");
	AST_REFILL: assert property (WORD_VALID && WORD_READY && WORD_REQUEST |=> WORD_VALID) else $error("refill");
	// Empty count means no sample was taken
	AST_ZERO_N: assert property (WORD_VALID && RESULT_WORD[COUNT_HI:COUNT_LO] == 0 |-> !RESULT_WORD[VALID_BIT])
		else $error("flag");
	AST_MODES_N: assert property ((REPLY_DONE && COMMIT_READY && MODE_SEL) ##3 (WORD_REQUEST && !WORD_VALID) |=>
		RESULT_WORD[COUNT_HI:COUNT_LO] == MODES_COUNT) else $error("count");
	cover property (REPLY_DONE && !COMMIT_READY);
	cover property (WORD_VALID && WORD_READY);
	cover property (WORD_REQUEST && WORD_VALID && !WORD_READY);
endmodule
bind aoa_word_framer aoa_chk chk (.MCLK(MCLK), .RESETN(RESETN), .MODE_SEL(MODE_SEL), .REPLY_DONE(REPLY_DONE),
	.COMMIT_READY(COMMIT_READY), .WORD_REQUEST(WORD_REQUEST), .WORD_VALID(WORD_VALID), .WORD_READY(WORD_READY),
	.RESULT_WORD(RESULT_WORD));

//--- sim/aoa_host.sv
// Reply processor stand-in draining result words
`timescale 1ns/10ps
module aoa_host
	import aoa_word_pkg::*;
#(
	parameter bit BOTTOM = 1'b1
)
(
	input wire logic clk,
	input wire logic stall,
	input wire logic valid,
	input wire logic [WORD_W-1:0] word,
	output logic ready,
	output logic [WORD_W-1:0] last,
	output logic [BEARING_W-1:0] heading,
	output int got
);
	// ======
	// Stall lets the bench fill the buffer
	assign ready = !stall;
	// Bottom antenna turns the other way
	assign heading = BOTTOM ? 8'h00 - last[BEARING_HI:BEARING_LO] : last[BEARING_HI:BEARING_LO];
	initial got = 0;
	always @(posedge clk)
		if (valid && ready)
		begin
			last <= word;
			got <= got + 1;
		end
endmodule

//--- sim/tb_angle_of_arrival_word_format.sv
// Bench for the result word framer
`timescale 1ns/10ps
module tb_angle_of_arrival_word_format;
	import aoa_word_pkg::*;
	logic clk = 0, rstn = 0, mode = 0, st = 0, smp = 0, dn = 0, rq = 0, stall = 0, rdy, cr, vld;
	logic [1:0] sd = 0, da = 0, dd = 0, ws = 0, rs = 0;
	logic [7:0] brg = 0, hd;
	logic [15:0] rw, last;
	int got, err_total = 0, samples_checked = 0;
	always #12.5 clk = !clk;
	aoa_word_framer uut (.MCLK(clk), .RESETN(rstn), .MODE_SEL(mode), .REPLY_START(st), .START_DECODER(sd),
		.SAMPLE_STROBE(smp), .DECODER_SLOT_ADDRESS(da), .AVG_BEARING(brg), .REPLY_DONE(dn), .DONE_DECODER(dd),
		.WRITE_SLOT(ws), .READ_SLOT(rs), .WORD_REQUEST(rq), .COMMIT_READY(cr), .WORD_VALID(vld),
		.WORD_READY(rdy), .RESULT_WORD(rw));
	aoa_host host (.clk(clk), .stall(stall), .valid(vld), .word(rw), .ready(rdy), .last(last), .heading(hd), .got(got));
	task automatic chk(input logic [15:0] g, e);
		samples_checked++;
		if (g !== e)
		begin
			err_total++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	// Done is held two cycles so the second one is refused
	task automatic reply(input logic [1:0] d, s, input int n, input logic [7:0] b, input logic [1:0] slot);
		@(posedge clk);
		st <= 1;
		sd <= d;
		@(posedge clk);
		st <= 0;
		smp <= 1;
		da <= s;
		brg <= b;
		repeat (n) @(posedge clk);
		smp <= 0;
		dn <= 1;
		dd <= mode ? 2'h2 : d;
		ws <= slot;
		@(posedge clk);
		@(negedge clk);
		chk(16'(cr), 16'h0000);
		@(posedge clk);
		dn <= 0;
	endtask
	task automatic fetch(input logic [1:0] slot, input logic [15:0] e, m);
		int n0;
		n0 = got;
		@(posedge clk);
		rq <= 1;
		rs <= slot;
		@(posedge clk);
		rq <= 0;
		repeat (20) if (got == n0) @(posedge clk);
		chk(16'(got - n0), 16'h0001);
		chk(last & m, e);
	endtask
	// ======
	// Scenarios
	task automatic atcrbs_words();
		reply(2'h2, 2'h2, 5, 8'ha5, 2'h3);
		reply(2'h0, 2'h3, 1, 8'h3c, 2'h1);
		fetch(2'h3, 16'h85a5, 16'hffff);
		fetch(2'h1, 16'h0000, 16'hff00);
	endtask
	task automatic modes_word();
		mode <= 1;
		reply(2'h1, 2'h3, 3, 8'h7e, 2'h2);
		fetch(2'h0, 16'ha07e, 16'hffff);
		chk({8'h00, hd}, 16'h0082);
	endtask
	task automatic fifo_fill();
		int n0;
		n0 = got;
		@(posedge clk);
		stall <= 1;
		rq <= 1;
		repeat (10) @(posedge clk);
		stall <= 0;
		// One more request while full and draining, it must be dropped
		@(posedge clk);
		rq <= 0;
		repeat (15) @(posedge clk);
		chk(16'(got - n0), 16'h0008);
		chk(16'(vld), 16'h0000);
		chk(last, 16'ha07e);
	endtask
	task automatic mid_reset();
		@(posedge clk);
		rstn <= 0;
		repeat (2) @(posedge clk);
		rstn <= 1;
		@(negedge clk);
		chk(16'(cr), 16'h0001);
		chk(16'(vld), 16'h0000);
		fetch(2'h1, 16'h0000, 16'hffff);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial
	begin
		repeat (10) @(posedge clk);
		rstn <= 1;
		atcrbs_words();
		modes_word();
		fifo_fill();
		mid_reset();
		tally_and_finish();
	end
	// Whole run is under a hundred cycles
	initial
	begin
		#50us;
		err_total++;
		tally_and_finish();
	end
endmodule
